// file: rfc_port.sv
/*
 * Receive flow control and indirect MAC register port, APB slave.
 * Assumes the host keeps the indirect registers still while busy, and that
 * the MAC register space answers an access with a one-cycle done pulse.
 */
// Notes on behaviour
// R1 - Count each dropped receive frame, 32 bits
// R2 - Reading drop count returns it, then clears
// R3 - Pulse event on count 7FFFFFFF to 80000000
// R4 - Writing busy one starts indirect MAC access
// R5 - Busy clears itself when access completes
// R6 - Host leaves command and data alone while busy
// R7 - Bit 30 one reads, zero writes
// R8 - Bits 7:0 select MAC register, reset zero
// R9 - Data register holds write or read value
// R10 - Transmitter disabled blocks pause and jam
// R11 - High threshold, 64-byte units, triggers flow control
// R12 - Full duplex high threshold sends one pause; the code sends it only when bit 0 is set
// R13 - Half duplex jams matching frames for duration
// R14 - Below low threshold sends zero-time pause
// R15 - Zero pause only after a threshold pause
// R16 - Software keeps low threshold under high
// R17 - Jam duration unused in full duplex
// R18 - Bit 3 jams on multicast frames
// R19 - Bit 2 jams on broadcast frames
// R20 - Bit 1 jams on own-address frames
// R21 - Bit 0 acts on any frame, overriding
// R22 - Duration code picks sixteen jam times
// R23 - Reserved bits read zero, writes ignored
`timescale 1ns/10ps
`default_nettype none

module rfc_port #(
	parameter int FIFO_LVL_W = 16
)
(
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	// Receive path status
	input  wire logic                  rx_frame_dropped,
	input  wire logic [FIFO_LVL_W-1:0] rx_fifo_level,
	input  wire logic                  rx_preamble,
	input  wire logic                  rx_is_multicast,
	input  wire logic                  rx_is_broadcast,
	input  wire logic                  rx_is_own_addr,
	input  wire logic                  rx_addr_valid,
	// MAC state
	input  wire logic                  tx_enabled,
	input  wire logic                  full_duplex,
	input  wire logic                  speed_100,
	// Indirect MAC register access
	output logic                       mac_req,
	output logic                       mac_rnw,
	output logic [7:0]                 mac_addr,
	output logic [31:0]                mac_wdata,
	input  wire logic                  mac_done,
	input  wire logic [31:0]           mac_rdata,
	// Flow control outputs
	output logic                       pause_req,
	output logic                       pause_zero,
	input  wire logic                  pause_ack,
	output logic                       jam_active,
	output logic                       drop_half_event
);

	// Elaboration check
	if (FIFO_LVL_W < rfc_pkg::AFC_THR_W + rfc_pkg::THR_UNIT_SHIFT)
		$error("rx_fifo_level too narrow for thresholds");

	typedef enum logic [1:0] {RFC_IDLE, RFC_REQ, RFC_WAIT} rfc_ind_t;

	// Register state
	logic [31:0] drop_q;
	logic        busy_q;
	logic        rnw_q;
	logic [7:0]  csr_addr_q;
	logic [31:0] data_q;
	logic [23:0] afc_q;
	rfc_ind_t    ind_q;
	rfc_ind_t    ind_d;
	logic        paused_q;
	logic        high_seen_q;
	logic        pause_req_q;
	logic        pause_zero_q;
	logic [22:0] jam_cnt_q;
	logic        half_ev_q;
	logic        rd_wait_q;

	// APB decode
	wire access   = psel && penable;
	wire wr       = access && pwrite;
	wire rd       = access && !pwrite;
	wire rd_first = rd && !rd_wait_q;
	wire sel_drop = (paddr == rfc_pkg::OFF_DROP_CNT);
	wire sel_cmd  = (paddr == rfc_pkg::OFF_IND_CMD);
	wire sel_data = (paddr == rfc_pkg::OFF_IND_DATA);
	wire sel_afc  = (paddr == rfc_pkg::OFF_AUTO_FLOW_CONFIG);
	wire mapped   = sel_drop || sel_cmd || sel_data || sel_afc;
	assign pready  = !rd || rd_wait_q; // One wait state on reads so prdata can come from a flop
	assign pslverr = access && !mapped;

	// Read mux; reserved bits come back as zero [R23]
	wire [31:0] cmd_word = {busy_q, rnw_q, 22'h00_0000, csr_addr_q};
	wire [31:0] rd_mux   = sel_drop ? drop_q :
	                       sel_cmd  ? cmd_word :
	                       sel_data ? data_q :
	                       sel_afc  ? {8'h00, afc_q} : rfc_pkg::RST_WORD;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata    <= rfc_pkg::RST_WORD;
			rd_wait_q <= 1'b0;
		end
		else
		begin
			rd_wait_q <= rd_first; // Read value is registered on the same edge that raises pready
			if (rd_first)
				prdata <= rd_mux;
		end
	end

	// Drop counter: read clears, a drop in the same cycle still counts [R1] [R2]
	wire drop_rd = rd_first && sel_drop;
	wire [31:0] drop_base = drop_rd ? rfc_pkg::RST_WORD : drop_q;
	wire [31:0] drop_inc  = drop_base + 32'h0000_0001;
	wire [31:0] drop_d    = rx_frame_dropped ? drop_inc : drop_base;
	wire        half_hit  = rx_frame_dropped && (drop_base == rfc_pkg::DROP_MID);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drop_q    <= rfc_pkg::RST_WORD;
			half_ev_q <= 1'b0;
		end
		else
		begin
			drop_q    <= drop_d;   // [R1] [R2]
			half_ev_q <= half_hit; // [R3]
		end
	end
	assign drop_half_event = half_ev_q;

	// Indirect access sequencer
	wire cmd_wr  = wr && sel_cmd && !busy_q;  // [R6]
	wire data_wr = wr && sel_data && !busy_q; // [R6]
	wire start   = cmd_wr && pwdata[rfc_pkg::CMD_BUSY_BIT];

	always_comb
	begin
		ind_d = ind_q;
		case (ind_q)
			RFC_IDLE: if (start) ind_d = RFC_REQ;         // [R4]
			RFC_REQ:  ind_d = mac_done ? RFC_IDLE : RFC_WAIT;
			RFC_WAIT: if (mac_done) ind_d = RFC_IDLE;     // [R5]
			default:  ind_d = RFC_IDLE;
		endcase
	end

	wire ind_fin = (ind_q != RFC_IDLE) && mac_done;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ind_q      <= RFC_IDLE;
			busy_q     <= 1'b0;
			rnw_q      <= 1'b0;
			csr_addr_q <= 8'h00;
			data_q     <= rfc_pkg::RST_WORD;
		end
		else
		begin
			ind_q <= ind_d;
			if (start)
				busy_q <= 1'b1;  // [R4]
			else if (ind_fin)
				busy_q <= 1'b0;  // [R5]
			if (cmd_wr)
			begin
				rnw_q      <= pwdata[rfc_pkg::CMD_RNW_BIT];                              // [R7]
				csr_addr_q <= pwdata[rfc_pkg::CMD_ADDR_LSB +: rfc_pkg::CMD_ADDR_W];      // [R8]
			end
			if (data_wr)
				data_q <= pwdata;    // [R9]
			else if (ind_fin && rnw_q)
				data_q <= mac_rdata; // [R5] [R9]
		end
	end

	assign mac_req   = (ind_q != RFC_IDLE);
	assign mac_rnw   = rnw_q;
	assign mac_addr  = csr_addr_q;
	assign mac_wdata = data_q;

	// Flow config: only bits 23:0 are stored [R23]
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			afc_q <= 24'h00_0000;
		else if (wr && sel_afc)
			afc_q <= pwdata[rfc_pkg::AFC_USED_W-1:0];
	end

	// Field views and threshold compare in 64-byte units
	wire [7:0] hi_thr   = afc_q[rfc_pkg::FLOW_HIGH_THRESHOLD_LSB +: rfc_pkg::AFC_THR_W];
	wire [7:0] lo_thr   = afc_q[rfc_pkg::FLOW_LOW_THRESHOLD_LSB +: rfc_pkg::AFC_THR_W];
	wire [3:0] dur_code = afc_q[rfc_pkg::AFC_DUR_LSB +: rfc_pkg::AFC_DUR_W];
	wire en_any = afc_q[rfc_pkg::AFC_ANY_BIT];
	wire en_mc  = afc_q[rfc_pkg::AFC_MC_BIT];
	wire en_bc  = afc_q[rfc_pkg::AFC_BC_BIT];
	wire en_own = afc_q[rfc_pkg::AFC_OWN_BIT];
	wire afc_on = en_any || en_mc || en_bc || en_own;
	wire [FIFO_LVL_W-1:0] lvl_units = rx_fifo_level >> rfc_pkg::THR_UNIT_SHIFT;
	wire at_high  = (lvl_units >= FIFO_LVL_W'(hi_thr)); // [R11]
	wire below_lo = (lvl_units <  FIFO_LVL_W'(lo_thr)); // [R14]

	// Full duplex pause, only with bit 0 set: one per crossing, zero-time after release [R12] [R14] [R15]
	wire fd_ok     = tx_enabled && full_duplex && afc_on;     // [R10]
	wire send_hi   = fd_ok && en_any && at_high && !paused_q && !pause_req_q; // [R12] [R21]
	wire send_zero = fd_ok && paused_q && below_lo && !pause_req_q;           // [R14] [R15]

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pause_req_q  <= 1'b0;
			pause_zero_q <= 1'b0;
			paused_q     <= 1'b0;
		end
		else
		begin
			if (pause_req_q && (pause_ack || !tx_enabled))
				pause_req_q <= 1'b0; // Withdraw if transmitter stops [R10]
			else if (send_hi || send_zero)
			begin
				pause_req_q  <= 1'b1;
				pause_zero_q <= send_zero;
			end
			if (send_hi)
				paused_q <= 1'b1;   // [R15]
			else if (send_zero)
				paused_q <= 1'b0;
		end
	end
	assign pause_req  = pause_req_q;
	assign pause_zero = pause_zero_q;

	// Half duplex jam: match selection, any frame overrides [R13] [R18] [R19] [R20] [R21]
	wire sel_match = en_any ? rx_preamble :
	                 rx_addr_valid && ((en_mc && rx_is_multicast) ||
	                                   (en_bc && rx_is_broadcast) ||
	                                   (en_own && rx_is_own_addr));
	wire hd_ok   = tx_enabled && !full_duplex; // Duration ignored in full duplex [R17] [R10]
	wire jam_go  = hd_ok && at_high && sel_match && (jam_cnt_q == 23'h00_0000);

	// Jam length per code and speed, rounded down to whole cycles [R22]
	wire [31:0] jam_ns = speed_100 ? 32'(rfc_pkg::JAM_BASE_100_NS + 1000 * rfc_pkg::jam_us(dur_code)) :
	                                 32'(rfc_pkg::JAM_BASE_10_NS + 1000 * rfc_pkg::jam_us(dur_code));
	wire [31:0] jam_cyc = jam_ns / 32'(rfc_pkg::CLK_NS);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			jam_cnt_q <= 23'h00_0000;
		else if (!hd_ok)
			jam_cnt_q <= 23'h00_0000;  // [R10] [R17]
		else if (jam_go)
			jam_cnt_q <= jam_cyc[22:0]; // [R13] [R22]
		else if (jam_cnt_q != 23'h00_0000)
			jam_cnt_q <= jam_cnt_q - 23'h00_0001;
	end
	assign jam_active = (jam_cnt_q != 23'h00_0000);

	// Assertions
	property p_drop_rc;
		@(posedge clk_sys) disable iff (!rst_n)
		(drop_rd && !rx_frame_dropped) |=> (drop_q == 32'h0000_0000);
	endproperty
	a_drop_rc: assert property (p_drop_rc) else $error("drop count not cleared by read"); // [R2]

	property p_drop_inc;
		@(posedge clk_sys) disable iff (!rst_n)
		(rx_frame_dropped && !drop_rd) |=> (drop_q == $past(drop_q) + 32'h0000_0001);
	endproperty
	a_drop_inc: assert property (p_drop_inc) else $error("drop count did not increment"); // [R1]

	property p_half;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(drop_q[31]) && ($past(drop_q) == 32'h7FFF_FFFF) |-> drop_half_event;
	endproperty
	a_half: assert property (p_half) else $error("halfway event missing"); // [R3]

	property p_busy_set;
		@(posedge clk_sys) disable iff (!rst_n)
		start |=> busy_q && mac_req;
	endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not set on start"); // [R4]

	property p_busy_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(busy_q && !mac_done) |=> busy_q;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early"); // [R5]

	property p_rd_data;
		@(posedge clk_sys) disable iff (!rst_n)
		(busy_q && mac_done && rnw_q) |=> (!busy_q && data_q == $past(mac_rdata));
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read data not captured"); // [R9]

	property p_tx_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!tx_enabled |=> !jam_active;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("jam while transmitter off"); // [R10]

	property p_zero_after;
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(pause_req) && pause_zero |-> $past(paused_q);
	endproperty
	a_zero_after: assert property (p_zero_after) else $error("zero pause without prior pause"); // [R15]

	property p_fd_nojam;
		@(posedge clk_sys) disable iff (!rst_n)
		full_duplex |=> !jam_active;
	endproperty
	a_fd_nojam: assert property (p_fd_nojam) else $error("jam in full duplex"); // [R17]

	property p_rsvd;
		@(posedge clk_sys) disable iff (!rst_n)
		(rd && sel_afc) |=> (prdata[31:24] == 8'h00);
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero"); // [R23]

	property p_data_read;
		@(posedge clk_sys) disable iff (!rst_n)
		(rd_first && sel_data) |=> (pready && prdata == $past(data_q));
	endproperty
	a_data_read: assert property (p_data_read) else $error("data register read wrong"); // [R9]

	property p_pause_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(pause_req && !pause_ack && tx_enabled) |=> pause_req;
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("pause request dropped early"); // [R12]

	property p_tx_off_pause;
		@(posedge clk_sys) disable iff (!rst_n)
		!tx_enabled |=> !pause_req;
	endproperty
	a_tx_off_pause: assert property (p_tx_off_pause) else $error("pause while transmitter off"); // [R10]

	c_ind: cover property (@(posedge clk_sys) disable iff (!rst_n) start ##[1:20] ind_fin);
	c_pause: cover property (@(posedge clk_sys) disable iff (!rst_n) send_hi ##[1:200] send_zero);
	c_jam: cover property (@(posedge clk_sys) disable iff (!rst_n) jam_go);
	c_rd_wait: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_first ##1 pready);
	c_slow_ind: cover property (@(posedge clk_sys) disable iff (!rst_n) start ##[5:40] ind_fin);

endmodule

`default_nettype wire

// file: rfc_pkg.sv
/*
 * Package for the receive flow control and indirect MAC register port.
 * Holds register offsets, field positions, reset values and timing constants.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package rfc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_DROP_CNT = 8'hA0;
	localparam logic [7:0] OFF_IND_CMD  = 8'hA4;
	localparam logic [7:0] OFF_IND_DATA = 8'hA8;
	localparam logic [7:0] OFF_AUTO_FLOW_CONFIG  = 8'hAC;

	// Indirect command fields
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_RNW_BIT  = 30;
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_ADDR_W   = 8;

	// Flow config fields
	localparam int FLOW_HIGH_THRESHOLD_LSB  = 16;
	localparam int FLOW_LOW_THRESHOLD_LSB  = 8;
	localparam int AFC_THR_W   = 8;
	localparam int AFC_DUR_LSB = 4;
	localparam int AFC_DUR_W   = 4;
	localparam int AFC_MC_BIT  = 3;
	localparam int AFC_BC_BIT  = 2;
	localparam int AFC_OWN_BIT = 1;
	localparam int AFC_ANY_BIT = 0;
	localparam int AFC_USED_W  = 24;

	// Reset value and drop count halfway mark
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [31:0] DROP_MID = 32'h7FFF_FFFF;

	// Threshold unit: FIFO level is in bytes, threshold in 64-byte units
	localparam int THR_UNIT_SHIFT = 6;

	// Timing: system clock and jam times in nanoseconds
	localparam int CLK_NS = 100;
	localparam int JAM_BASE_100_NS = 5000;
	localparam int JAM_BASE_10_NS  = 7200;

	// Jam time per code in microseconds, added to a 5 us base at 100 Mb/s; 10 Mb/s adds 2.2 us more
	function automatic int jam_us(input logic [3:0] code);
		case (code)
			4'h0: jam_us = 0;
			4'h1: jam_us = 5;
			4'h2: jam_us = 10;
			4'h3: jam_us = 20;
			default: jam_us = 45 + 50 * (int'(code) - 4);
		endcase
	endfunction

endpackage

// file: rfc_mac_model.sv
/*
 * Behavioural far side of the port: MAC register space and pause transmitter.
 * Assumes the port holds mac_req and its qualifiers still until mac_done.
 */
`timescale 1ns/10ps
`default_nettype none

module rfc_mac_model
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Indirect access
	input  wire logic        mac_req,
	input  wire logic        mac_rnw,
	input  wire logic [7:0]  mac_addr,
	input  wire logic [31:0] mac_wdata,
	input  wire logic [7:0]  mac_lat,
	output logic             mac_done,
	output logic [31:0]      mac_rdata,
	// Pause handshake
	input  wire logic        pause_req,
	input  wire logic        pause_zero,
	output logic             pause_ack,
	output int               n_pause,
	output int               n_zero
);
	logic [31:0] regs_q [256];
	logic [7:0]  wait_q;
	logic [1:0]  ack_q;

	// Read data toggles outside done so a stale value never looks valid
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 256; i++)
				regs_q[i] <= {24'h5A5A_5A, i[7:0]};
			mac_done <= 1'b0;
			mac_rdata <= 32'h0000_0000;
			wait_q <= 8'h00;
		end
		else
		begin
			mac_done <= 1'b0;
			mac_rdata <= ~mac_rdata;
			if (mac_req && !mac_done && wait_q >= mac_lat)
			begin
				mac_done <= 1'b1;
				wait_q <= 8'h00;
				if (mac_rnw)
					mac_rdata <= regs_q[mac_addr];
				else
					regs_q[mac_addr] <= mac_wdata;
			end
			else if (mac_req && !mac_done)
				wait_q <= wait_q + 8'h01;
		end
	end

	// Transmitter takes a pause request four cycles late and counts its kind
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pause_ack <= 1'b0;
			ack_q <= 2'h0;
			n_pause <= 0;
			n_zero <= 0;
		end
		else
		begin
			pause_ack <= 1'b0;
			ack_q <= (pause_req && !pause_ack) ? ack_q + 2'h1 : 2'h0;
			if (ack_q == 2'h3)
			begin
				pause_ack <= 1'b1;
				ack_q <= 2'h0;
				if (pause_zero)
					n_zero <= n_zero + 1;
				else
					n_pause <= n_pause + 1;
			end
		end
	end
endmodule

`default_nettype wire

// file: rfc_port_bench.sv
/*
 * Self-checking bench for the flow control and indirect register port.
 * Assumes the port answers reads after one wait state and writes at once.
 */
`timescale 1ns/10ps
`default_nettype none

module rfc_port_bench;
	logic        clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        rx_frame_dropped = 1'b0, rx_preamble = 1'b0, rx_is_multicast = 1'b0, rx_is_broadcast = 1'b0;
	logic        rx_is_own_addr = 1'b0, rx_addr_valid = 1'b0, tx_enabled = 1'b1, full_duplex = 1'b1;
	logic        speed_100 = 1'b1, pready, pslverr, mac_req, mac_rnw, mac_done, pause_req, pause_zero;
	logic        pause_ack, jam_active, drop_half_event, er;
	logic [7:0]  paddr = 8'h00, mac_lat = 8'h00, mac_addr;
	logic [15:0] rx_fifo_level = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, mac_wdata, mac_rdata, rd;
	int          fails = 0, comparisons = 0, n_pause, n_zero, jn;

	// Clock at 10 MHz
	always #50 clk_sys = ~clk_sys;

	rfc_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.rx_frame_dropped(rx_frame_dropped), .rx_fifo_level(rx_fifo_level), .rx_preamble(rx_preamble),
		.rx_is_multicast(rx_is_multicast), .rx_is_broadcast(rx_is_broadcast), .rx_is_own_addr(rx_is_own_addr),
		.rx_addr_valid(rx_addr_valid), .tx_enabled(tx_enabled), .full_duplex(full_duplex),
		.speed_100(speed_100), .mac_req(mac_req), .mac_rnw(mac_rnw), .mac_addr(mac_addr),
		.mac_wdata(mac_wdata), .mac_done(mac_done), .mac_rdata(mac_rdata), .pause_req(pause_req),
		.pause_zero(pause_zero), .pause_ack(pause_ack), .jam_active(jam_active),
		.drop_half_event(drop_half_event));

	rfc_mac_model u_mac (.clk_sys(clk_sys), .rst_n(rst_n), .mac_req(mac_req), .mac_rnw(mac_rnw),
		.mac_addr(mac_addr), .mac_wdata(mac_wdata), .mac_lat(mac_lat), .mac_done(mac_done),
		.mac_rdata(mac_rdata), .pause_req(pause_req), .pause_zero(pause_zero), .pause_ack(pause_ack),
		.n_pause(n_pause), .n_zero(n_zero));

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One APB transfer; pready and read data are looked at settled, then taken at the next rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic ok;
		n = 0;
		ok = 1'b0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
		begin
			@(negedge clk_sys);
			ok = (pready === 1'b1);
			rd = prdata;
			er = pslverr;
			@(posedge clk_sys);
			n++;
		end
		while (!ok && n < 50);
		if (!ok)
		begin
			fails++;
			$display("unexpected at %0t: no pready", $time);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Host waits for busy to clear before touching the indirect registers
	task poll;
		int k;
		k = 0;
		do
		begin
			apb(1'b0, rfc_pkg::OFF_IND_CMD, 32'h0000_0000);
			k++;
		end
		while (rd[31] !== 1'b0 && k < 50);
		chk(rd[31], 1'b0, "busy cleared");
	endtask

	// Configure, send one classified frame, count jam cycles over the expected count plus 20 cycles
	task jam_case(input logic [7:0] cfg, input logic [2:0] cls, input logic fd, input logic sp,
		input logic tx, input logic [15:0] lvl, input int exp);
		apb(1'b1, rfc_pkg::OFF_AUTO_FLOW_CONFIG, {8'h00, 8'h02, 8'h01, cfg});
		@(posedge clk_sys);
		full_duplex <= fd;
		speed_100 <= sp;
		tx_enabled <= tx;
		rx_fifo_level <= lvl;
		@(posedge clk_sys);
		rx_preamble <= 1'b1;
		rx_addr_valid <= 1'b1;
		{rx_is_multicast, rx_is_broadcast, rx_is_own_addr} <= cls;
		@(posedge clk_sys);
		rx_preamble <= 1'b0;
		rx_addr_valid <= 1'b0;
		{rx_is_multicast, rx_is_broadcast, rx_is_own_addr} <= 3'h0;
		jn = 0;
		for (int i = 0; i < exp + 20; i++)
		begin
			#1 if (jam_active === 1'b1) jn++;
			@(posedge clk_sys);
		end
		chk(jn, exp, "jam cycles");
	endtask

	task test_done;
		$display("mismatches %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog at 10000 cycles, well beyond the thousand or so cycles the tests need
	initial
	begin
		#1_000_000;
		fails++;
		$display("unexpected at %0t: timeout", $time);
		test_done;
	end

	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		apb(1'b0, rfc_pkg::OFF_DROP_CNT, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "drop reset");
		apb(1'b0, rfc_pkg::OFF_IND_CMD, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "cmd reset");
		apb(1'b0, rfc_pkg::OFF_IND_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "data reset");
		apb(1'b0, 8'hB0, 32'h0000_0000);
		chk({rd[30:0], er}, 32'h0000_0001, "unmapped read");
		apb(1'b1, rfc_pkg::OFF_AUTO_FLOW_CONFIG, 32'hFFFF_FFFF);
		apb(1'b0, rfc_pkg::OFF_AUTO_FLOW_CONFIG, 32'h0000_0000);
		chk(rd, 32'h00FF_FFFF, "cfg reserved");
		apb(1'b1, rfc_pkg::OFF_IND_CMD, 32'h3FFF_FF12);
		apb(1'b0, rfc_pkg::OFF_IND_CMD, 32'h0000_0000);
		chk(rd, 32'h0000_0012, "cmd reserved");
		repeat (3)
		begin
			@(posedge clk_sys);
			rx_frame_dropped <= 1'b1;
			@(posedge clk_sys);
			rx_frame_dropped <= 1'b0;
		end
		apb(1'b0, rfc_pkg::OFF_DROP_CNT, 32'h0000_0000);
		chk(rd, 32'h0000_0003, "drop count");
		chk(drop_half_event, 1'b0, "no halfway event");
		apb(1'b0, rfc_pkg::OFF_DROP_CNT, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "drop clear on read");
		// Slow write: command and data writes while busy must be refused
		mac_lat <= 8'h1E;
		apb(1'b1, rfc_pkg::OFF_IND_DATA, 32'hCAFE_0007);
		apb(1'b1, rfc_pkg::OFF_IND_CMD, 32'h8000_0007);
		apb(1'b0, rfc_pkg::OFF_IND_CMD, 32'h0000_0000);
		chk(rd[31], 1'b1, "busy held");
		apb(1'b1, rfc_pkg::OFF_IND_DATA, 32'h1234_5678);
		apb(1'b1, rfc_pkg::OFF_IND_CMD, 32'hC000_0033);
		poll;
		chk(u_mac.regs_q[7], 32'hCAFE_0007, "indirect write");
		apb(1'b0, rfc_pkg::OFF_IND_DATA, 32'h0000_0000);
		chk(rd, 32'hCAFE_0007, "data kept while busy");
		// Prompt read
		mac_lat <= 8'h00;
		apb(1'b1, rfc_pkg::OFF_IND_CMD, 32'hC000_0009);
		poll;
		apb(1'b0, rfc_pkg::OFF_IND_DATA, 32'h0000_0000);
		chk(rd, 32'h5A5A_5A09, "indirect read");
		apb(1'b0, rfc_pkg::OFF_IND_CMD, 32'h0000_0000);
		chk(rd, 32'h4000_0009, "cmd after read");
		// Full duplex pause sequence
		apb(1'b1, rfc_pkg::OFF_AUTO_FLOW_CONFIG, 32'h0002_0101);
		repeat (20) @(posedge clk_sys);
		chk(n_zero, 0, "zero pause without pause");
		rx_fifo_level <= 16'h0080;
		repeat (40) @(posedge clk_sys);
		chk(n_pause, 1, "single pause");
		rx_fifo_level <= 16'h0000;
		repeat (20) @(posedge clk_sys);
		chk(n_zero, 1, "zero pause");
		tx_enabled <= 1'b0;
		rx_fifo_level <= 16'h0080;
		repeat (20) @(posedge clk_sys);
		chk(n_pause, 1, "no pause with tx off");
		// Half duplex back pressure by frame class, code and speed
		jam_case(8'h08, 3'h4, 1'b0, 1'b1, 1'b1, 16'h0080, 50);
		jam_case(8'h08, 3'h2, 1'b0, 1'b1, 1'b1, 16'h0080, 0);
		jam_case(8'h34, 3'h2, 1'b0, 1'b1, 1'b1, 16'h0080, 250);
		jam_case(8'h02, 3'h1, 1'b0, 1'b0, 1'b1, 16'h0080, 72);
		jam_case(8'h11, 3'h0, 1'b0, 1'b1, 1'b1, 16'h0080, 100);
		jam_case(8'h08, 3'h4, 1'b1, 1'b1, 1'b1, 16'h0080, 0);
		jam_case(8'h08, 3'h4, 1'b0, 1'b1, 1'b0, 16'h0080, 0);
		jam_case(8'h08, 3'h4, 1'b0, 1'b1, 1'b1, 16'h007F, 0);
		test_done;
	end
endmodule

`default_nettype wire
